// file: core/partition_id_narrowing_cfg.sv
`timescale 1ns/1ps

// Behaviour
// - feature register shows vendor register presence
// - readable implementer identification register
// - no vendor controls reads flag one
// - no vendor monitors reads flag one
// - downstream keeps original request partition id
// - map request id before settings lookup
// - map register writes and reads association
// - bad mapping records dedicated error code
// - narrowing: selector is internal id
// - no narrowing: selector is request id
// - reset gives default partition full resource
// - only default partition settings reset
// - default reset: ones, ffff, stride off
// - request zero maps internal zero
// - sixteen bit fraction, low bits zero
// - surplus fraction write bits dropped silently
// - limits use top of fraction range
// - sub-line request costs a full line
module partition_id_narrowing_cfg #(
   parameter bit NARROW = 1'b1,
   parameter int NUM_INT = 6,
   parameter int CPOR_W = 16,
   parameter int PBM_W = 16,
   parameter int FRAC_W = 16,
   parameter bit HAS_VENDOR = 1'b1,
   // Vendor feature word; zero halves mean no vendor controls or monitors.
   parameter logic [31:0] VENDOR_FEAT = 32'h0000_0000,
   // Identification value is arbitrary.
   parameter logic [31:0] IDENT = 32'h0000_0a5a
) (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_i,
   // Register port.
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Requests in and looked-up settings out.
   input wire logic req_valid_i,
   input wire part_narrow_pkg::req_t req_i,
   output logic res_valid_o,
   output part_narrow_pkg::res_t res_o
);

   localparam int PW = part_narrow_pkg::PID_W;
   localparam int INT_W = (NUM_INT > 1) ? $clog2(NUM_INT) : 1;
   localparam int CFG_W = NARROW ? INT_W : PW;
   localparam int NUM_CFG = 2 << CFG_W;
   localparam int NUM_MAP = 2 << PW;
   localparam logic [15:0] LOW_MASK = 16'((17'h1 << (16 - FRAC_W)) - 17'h1);

   function automatic logic [15:0] frac_rd(input logic [FRAC_W-1:0] f);
      frac_rd = 16'(f) << (16 - FRAC_W);
   endfunction : frac_rd

   function automatic logic [16:0] frac_top(input logic [FRAC_W-1:0] f);
      frac_top = 17'({f, {(17 - FRAC_W){1'b1}}});
   endfunction : frac_top

   // Selector and error state.
   logic [31:0] sel_q;
   logic [3:0] err_q;
   logic [3:0] err_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // Settings, indexed by {space, partition}.
   logic [CPOR_W-1:0] cpor_q [NUM_CFG];
   logic [FRAC_W-1:0] cmax_q [NUM_CFG];
   logic [PBM_W-1:0] pbm_q [NUM_CFG];
   logic [FRAC_W-1:0] bmax_q [NUM_CFG];
   logic stride_en_q [NUM_CFG];
   logic [15:0] stride_q [NUM_CFG];
   logic [PW-1:0] map_q [NUM_MAP];
   logic [NUM_MAP-1:0] map_vld_q;

   logic res_valid_q;
   part_narrow_pkg::res_t res_q;
   part_narrow_pkg::res_t res_d;

   // Selector decode.
   wire sel_int = sel_q[part_narrow_pkg::SEL_INT_BIT];
   wire sel_space = sel_q[part_narrow_pkg::SEL_SPACE_BIT];
   wire [PW-1:0] sel_pid = sel_q[PW-1:0];
   wire [CFG_W:0] sel_idx = {sel_space, sel_pid[CFG_W-1:0]};
   wire [PW:0] sel_map_idx = {sel_space, sel_pid};
   wire sel_in_range = !NARROW || (32'(sel_pid) < NUM_INT);
   wire sel_flag_ok = NARROW ? sel_int : !sel_int;
   wire cfg_ok = sel_flag_ok && sel_in_range;
   wire map_ok = NARROW && !sel_int;

   // Address decode.
   wire hit_cpor = addr_i == part_narrow_pkg::CPOR_OFS;
   wire hit_cmax = addr_i == part_narrow_pkg::CMAX_OFS;
   wire hit_pbm = addr_i == part_narrow_pkg::PBM_OFS;
   wire hit_bmax = addr_i == part_narrow_pkg::BMAX_OFS;
   wire hit_stride = addr_i == part_narrow_pkg::STRIDE_OFS;
   wire hit_map = addr_i == part_narrow_pkg::MAP_OFS;
   wire hit_cfg = hit_cpor || hit_cmax || hit_pbm || hit_bmax || hit_stride;
   wire acc = wr_i || rd_i;
   wire wr_cfg = wr_i && hit_cfg && cfg_ok;
   wire wr_map_val_ok = 32'(wdata_i[PW-1:0]) < NUM_INT;
   wire wr_map = wr_i && hit_map && map_ok && wr_map_val_ok;
   wire wr_sel = wr_i && addr_i == part_narrow_pkg::SEL_OFS;
   wire wr_err = wr_i && addr_i == part_narrow_pkg::ERR_OFS;

   // Request lookup: request id to internal id, then settings.
   wire [PW:0] req_map_idx = {req_i.space, req_i.pid};
   wire req_bad = NARROW && !map_vld_q[req_map_idx];
   wire [PW-1:0] req_int = NARROW ? map_q[req_map_idx] : req_i.pid;
   wire [CFG_W:0] req_idx = {req_i.space, req_int[CFG_W-1:0]};

   // Error detection; a new event wins over a software clear.
   wire err_flag = acc && ((hit_cfg && !sel_flag_ok) || (hit_map && !map_ok));
   wire err_range = acc && hit_cfg && sel_flag_ok && !sel_in_range;
   wire err_map = (wr_i && hit_map && map_ok && !wr_map_val_ok) || (req_valid_i && req_bad);

   always_comb begin
      err_d = err_q;
      if (err_map) begin
         err_d = part_narrow_pkg::ERR_BAD_MAP;
      end else if (err_flag) begin
         err_d = part_narrow_pkg::ERR_SEL_FLAG;
      end else if (err_range) begin
         err_d = part_narrow_pkg::ERR_SEL_RANGE;
      end else if (wr_err) begin
         err_d = part_narrow_pkg::ERR_NONE;
      end
   end

   // Register read mux.
   wire no_part = VENDOR_FEAT[part_narrow_pkg::VFEAT_MON_LSB-1:0] == '0;
   wire no_mon = VENDOR_FEAT[31:part_narrow_pkg::VFEAT_MON_LSB] == '0;
   wire [31:0] feat_word = (32'(HAS_VENDOR) << part_narrow_pkg::FEAT_VIDR_BIT)
      | (32'(no_part) << part_narrow_pkg::FEAT_NOPART_BIT)
      | (32'(no_mon) << part_narrow_pkg::FEAT_NOMON_BIT)
      | (32'(NARROW) << part_narrow_pkg::FEAT_NARROW_BIT)
      | (32'(NUM_INT) << part_narrow_pkg::FEAT_NUMINT_LSB);
   wire [31:0] map_word = {map_vld_q[sel_map_idx], 31'(map_q[sel_map_idx])};
   wire [31:0] stride_word = {stride_en_q[sel_idx], 15'h0, stride_q[sel_idx]};

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_i) begin
         unique case (addr_i)
            part_narrow_pkg::FEAT_OFS: rdata_d = feat_word;
            part_narrow_pkg::IDENT_OFS: rdata_d = IDENT;
            part_narrow_pkg::VFEAT_OFS: rdata_d = HAS_VENDOR ? VENDOR_FEAT : 32'h0;
            part_narrow_pkg::SEL_OFS: rdata_d = sel_q;
            part_narrow_pkg::ERR_OFS: rdata_d = 32'(err_q);
            part_narrow_pkg::MAP_OFS: rdata_d = map_ok ? map_word : 32'h0;
            part_narrow_pkg::CPOR_OFS: rdata_d = cfg_ok ? 32'(cpor_q[sel_idx]) : 32'h0;
            part_narrow_pkg::CMAX_OFS: begin
               rdata_d = cfg_ok ? 32'(frac_rd(cmax_q[sel_idx])) : 32'h0;
            end
            part_narrow_pkg::PBM_OFS: rdata_d = cfg_ok ? 32'(pbm_q[sel_idx]) : 32'h0;
            part_narrow_pkg::BMAX_OFS: begin
               rdata_d = cfg_ok ? 32'(frac_rd(bmax_q[sel_idx])) : 32'h0;
            end
            part_narrow_pkg::STRIDE_OFS: rdata_d = cfg_ok ? stride_word : 32'h0;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Lookup result; the original request id goes downstream.
   always_comb begin
      res_d.req_pid = req_i.pid;
      res_d.space = req_i.space;
      res_d.int_pid = req_int;
      res_d.bad_map = req_bad;
      res_d.cpor = 16'(cpor_q[req_idx]);
      res_d.cmax_top = frac_top(cmax_q[req_idx]);
      res_d.pbm = 16'(pbm_q[req_idx]);
      res_d.bmax_top = frac_top(bmax_q[req_idx]);
      res_d.stride_en = stride_en_q[req_idx];
      res_d.stride = stride_q[req_idx];
      res_d.cost = (req_i.bytes < part_narrow_pkg::LINE_BYTES) ?
         part_narrow_pkg::LINE_BYTES : req_i.bytes;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sel_q <= 32'h0000_0000;
         err_q <= part_narrow_pkg::ERR_NONE;
         rdata_q <= 32'h0000_0000;
         res_valid_q <= 1'b0;
         res_q <= '0;
      end else begin
         if (wr_sel) begin
            sel_q <= wdata_i;
         end
         err_q <= err_d;
         rdata_q <= rdata_d;
         res_valid_q <= req_valid_i;
         res_q <= res_d;
      end
   end

   // Only the default partition of each space is reset; others stay as they are.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         for (int s = 0; s < 2; s++) begin
            cpor_q[s << CFG_W] <= '1;
            cmax_q[s << CFG_W] <= part_narrow_pkg::CMAX_RST[15 -: FRAC_W];
            pbm_q[s << CFG_W] <= '1;
            bmax_q[s << CFG_W] <= part_narrow_pkg::BMAX_RST[15 -: FRAC_W];
            stride_en_q[s << CFG_W] <= part_narrow_pkg::STRIDE_EN_RST;
            stride_q[s << CFG_W] <= part_narrow_pkg::STRIDE_RST;
         end
      end else if (wr_cfg) begin
         if (hit_cpor) begin
            cpor_q[sel_idx] <= wdata_i[CPOR_W-1:0];
         end
         if (hit_cmax) begin
            cmax_q[sel_idx] <= wdata_i[15 -: FRAC_W];
         end
         if (hit_pbm) begin
            pbm_q[sel_idx] <= wdata_i[PBM_W-1:0];
         end
         if (hit_bmax) begin
            bmax_q[sel_idx] <= wdata_i[15 -: FRAC_W];
         end
         if (hit_stride) begin
            stride_en_q[sel_idx] <= wdata_i[part_narrow_pkg::STRIDE_EN_BIT];
            stride_q[sel_idx] <= wdata_i[15:0];
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         map_vld_q <= '0;
         for (int s = 0; s < 2; s++) begin
            map_vld_q[s << PW] <= 1'b1;
            map_q[s << PW] <= part_narrow_pkg::DEFAULT_PID;
         end
      end else if (wr_map) begin
         map_q[sel_map_idx] <= wdata_i[PW-1:0];
         map_vld_q[sel_map_idx] <= 1'b1;
      end
   end

   assign rdata_o = rdata_q;
   assign res_valid_o = res_valid_q;
   assign res_o = res_q;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   sequence s_map_write;
      wr_i && hit_map && map_ok && wr_map_val_ok;
   endsequence

   sequence s_map_read;
      rd_i && hit_map && !wr_sel;
   endsequence

   property p_feat_flags;
      rd_i && addr_i == part_narrow_pkg::FEAT_OFS |=>
         rdata_o[part_narrow_pkg::FEAT_NOPART_BIT] == no_part
         && rdata_o[part_narrow_pkg::FEAT_NOMON_BIT] == no_mon
         && rdata_o[part_narrow_pkg::FEAT_VIDR_BIT] == HAS_VENDOR;
   endproperty
   a_feat_flags: assert property (p_feat_flags) else $error("feature flags wrong");

   property p_ident;
      rd_i && addr_i == part_narrow_pkg::IDENT_OFS |=> rdata_o == IDENT;
   endproperty
   a_ident: assert property (p_ident) else $error("ident read wrong");

   property p_idle_zero;
      !rd_i |=> rdata_o == 32'h0;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("read data outside slot");

   property p_keep_pid;
      req_valid_i |=> res_valid_o && res_o.req_pid == $past(req_i.pid);
   endproperty
   a_keep_pid: assert property (p_keep_pid) else $error("request id altered");

   // An unmapped request carries no defined internal id, so only mapped ones are compared.
   property p_lookup;
      req_valid_i && NARROW |=> res_o.bad_map || res_o.int_pid == $past(map_q[req_map_idx]);
   endproperty
   a_lookup: assert property (p_lookup) else $error("lookup not mapped");

   // A write, one quiet cycle that leaves the selector alone, then a read of the same entry.
   property p_map_back;
      s_map_write ##1 !wr_i ##1 s_map_read |=>
         rdata_o[PW-1:0] == $past(wdata_i[PW-1:0], 3) && rdata_o[part_narrow_pkg::MAP_VALID_BIT];
   endproperty
   a_map_back: assert property (p_map_back) else $error("map readback wrong");

   property p_bad_map;
      wr_i && hit_map && map_ok && !wr_map_val_ok |=> err_q == part_narrow_pkg::ERR_BAD_MAP;
   endproperty
   a_bad_map: assert property (p_bad_map) else $error("bad map not flagged");

   property p_flag_guard;
      wr_i && hit_cfg && !sel_flag_ok |=> err_q != part_narrow_pkg::ERR_NONE
         && cpor_q[$past(sel_idx)] === $past(cpor_q[sel_idx]);
   endproperty
   a_flag_guard: assert property (p_flag_guard) else $error("flag misuse accepted");

   property p_reset_default;
      $past(rst_i) |-> cmax_q[0] == part_narrow_pkg::CMAX_RST[15 -: FRAC_W]
         && !stride_en_q[0] && map_vld_q[0] && map_q[0] == part_narrow_pkg::DEFAULT_PID;
   endproperty
   a_reset_default: assert property (p_reset_default) else $error("default not reset");

   property p_trunc;
      rd_i && (hit_cmax || hit_bmax) |=> (rdata_o[15:0] & LOW_MASK) == 16'h0;
   endproperty
   a_trunc: assert property (p_trunc) else $error("low fraction bits set");

   property p_cost;
      res_valid_o |-> res_o.cost >= part_narrow_pkg::LINE_BYTES;
   endproperty
   a_cost: assert property (p_cost) else $error("cost below line");

   property p_res_idle;
      !req_valid_i |=> !res_valid_o;
   endproperty
   a_res_idle: assert property (p_res_idle) else $error("result without request");

   property p_err_set_wins;
      wr_err && (err_map || err_flag || err_range) |=> err_q != part_narrow_pkg::ERR_NONE;
   endproperty
   a_err_set_wins: assert property (p_err_set_wins) else $error("error lost to clear");

   property p_range_guard;
      acc && hit_cfg && sel_flag_ok && !sel_in_range |=>
         err_q != part_narrow_pkg::ERR_NONE && rdata_o == 32'h0;
   endproperty
   a_range_guard: assert property (p_range_guard) else $error("range misuse accepted");

   property p_map_flag;
      rd_i && hit_map && !map_ok |=> rdata_o == 32'h0 && err_q != part_narrow_pkg::ERR_NONE;
   endproperty
   a_map_flag: assert property (p_map_flag) else $error("map read misuse accepted");

endmodule : partition_id_narrowing_cfg

// file: include/part_narrow_pkg.sv
package part_narrow_pkg;

   localparam int PID_W = 8;
   localparam int FRAC_DOC_W = 16;

   // Register byte offsets.
   localparam logic [7:0] FEAT_OFS = 8'h00;
   localparam logic [7:0] IDENT_OFS = 8'h04;
   localparam logic [7:0] VFEAT_OFS = 8'h08;
   localparam logic [7:0] SEL_OFS = 8'h0c;
   localparam logic [7:0] ERR_OFS = 8'h10;
   localparam logic [7:0] MAP_OFS = 8'h14;
   localparam logic [7:0] CPOR_OFS = 8'h18;
   localparam logic [7:0] CMAX_OFS = 8'h1c;
   localparam logic [7:0] PBM_OFS = 8'h20;
   localparam logic [7:0] BMAX_OFS = 8'h24;
   localparam logic [7:0] STRIDE_OFS = 8'h28;

   // Field positions.
   localparam int FEAT_VIDR_BIT = 0;
   localparam int FEAT_NOPART_BIT = 1;
   localparam int FEAT_NOMON_BIT = 2;
   localparam int FEAT_NARROW_BIT = 3;
   localparam int FEAT_NUMINT_LSB = 16;
   localparam int SEL_INT_BIT = 16;
   localparam int SEL_SPACE_BIT = 24;
   localparam int MAP_VALID_BIT = 31;
   localparam int STRIDE_EN_BIT = 31;
   localparam int VFEAT_MON_LSB = 16;

   // Error codes held in the error status register.
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_SEL_RANGE = 4'h1;
   localparam logic [3:0] ERR_SEL_FLAG = 4'h2;
   localparam logic [3:0] ERR_BAD_MAP = 4'h3;

   // Values after reset of the default partition, and the line size in bytes.
   localparam logic [PID_W-1:0] DEFAULT_PID = 8'h00;
   localparam logic [15:0] CMAX_RST = 16'hffff;
   localparam logic [15:0] BMAX_RST = 16'hffff;
   localparam logic STRIDE_EN_RST = 1'b0;
   localparam logic [15:0] STRIDE_RST = 16'h0000;
   localparam logic [6:0] LINE_BYTES = 7'h40;

   typedef struct packed {
      logic [PID_W-1:0] pid;
      logic space;
      logic [6:0] bytes;
   } req_t;

   typedef struct packed {
      logic [PID_W-1:0] req_pid;
      logic space;
      logic [PID_W-1:0] int_pid;
      logic bad_map;
      logic [15:0] cpor;
      logic [16:0] cmax_top;
      logic [15:0] pbm;
      logic [16:0] bmax_top;
      logic stride_en;
      logic [15:0] stride;
      logic [6:0] cost;
   } res_t;

endpackage : part_narrow_pkg

// file: test/req_source.sv
`timescale 1ns/1ps

module req_source (
   // Clock.
   input wire logic clock_i,
   // Requests towards the block.
   output logic req_valid_o,
   output part_narrow_pkg::req_t req_o
);
   initial begin
      req_valid_o = 1'b0;
      req_o = '0;
   end

   // Waits gap plus one clock edges, then holds one request for a single cycle.
   // Afterwards the fields flip so stale values are never mistaken for a request.
   task automatic send(input logic [7:0] pid, input logic space, input logic [6:0] bytes,
                       input int gap);
      repeat (gap) @(posedge clock_i);
      @(posedge clock_i);
      req_valid_o <= 1'b1;
      req_o <= '{pid, space, bytes};
      @(posedge clock_i);
      req_valid_o <= 1'b0;
      req_o <= ~req_o;
   endtask : send
endmodule : req_source

// file: test/testbench.sv
`timescale 1ns/1ps

module testbench;
   localparam int FW = 12;
   localparam int NI = 6;
   // Identification value is arbitrary.
   localparam logic [31:0] ID_VAL = 32'h0000_3c71;
   localparam logic [15:0] LOWM = 16'((1 << (16 - FW)) - 1);
   logic clock_i, rst_i, wr_i, rd_i, req_valid_i, res_valid_o;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o;
   part_narrow_pkg::req_t req_i;
   part_narrow_pkg::res_t res_o;
   logic [31:0] rdata_n_o;
   logic res_n_valid_o;
   part_narrow_pkg::res_t res_n_o;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   int map_m[2][256];
   logic [31:0] cfg_m[2][256][5];
   logic [31:0] cmask[5];
   int sel_id, sel_int, sel_sp, err_m;

   partition_id_narrowing_cfg #(.NUM_INT(NI), .FRAC_W(FW), .IDENT(ID_VAL)) dut_u (
      .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .req_valid_i(req_valid_i), .req_i(req_i),
      .res_valid_o(res_valid_o), .res_o(res_o));

   req_source src_u (.clock_i(clock_i), .req_valid_o(req_valid_i), .req_o(req_i));

   // Second copy without narrowing; it sees the same bus and the same requests.
   partition_id_narrowing_cfg #(.NARROW(1'b0), .NUM_INT(NI), .FRAC_W(FW), .IDENT(ID_VAL),
      .VENDOR_FEAT(32'h0001_0000)) dut_direct_u (
      .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_n_o), .req_valid_i(req_valid_i), .req_i(req_i),
      .res_valid_o(res_n_valid_o), .res_o(res_n_o));

   // Reference model of one register access; returns the expected read value.
   function automatic logic [31:0] model(input bit w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = (int'(a) - 'h18) / 4;
      model = '0;
      if (a == part_narrow_pkg::FEAT_OFS) begin
         model = {16'(NI), 16'h000f};
      end else if (a == part_narrow_pkg::IDENT_OFS) begin
         model = ID_VAL;
      end else if (a == part_narrow_pkg::SEL_OFS && w) begin
         sel_id = d[7:0];
         sel_int = d[16];
         sel_sp = d[24];
      end else if (a == part_narrow_pkg::ERR_OFS) begin
         if (w) err_m = 0;
         else model = 32'(err_m);
      end else if (a == part_narrow_pkg::MAP_OFS) begin
         if (sel_int != 0) err_m = 2;
         else if (w && d[7:0] >= NI) err_m = 3;
         else if (w) map_m[sel_sp][sel_id] = d[7:0];
         else model = {1'b1, 23'h0, 8'(map_m[sel_sp][sel_id])};
      end else if (a >= part_narrow_pkg::CPOR_OFS && a <= part_narrow_pkg::STRIDE_OFS) begin
         if (sel_int == 0) err_m = 2;
         else if (sel_id >= NI) err_m = 1;
         else if (w) cfg_m[sel_sp][sel_id][k] = d & cmask[k];
         else model = cfg_m[sel_sp][sel_id][k];
      end
   endfunction : model

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t read %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      void'(model(1'b1, a, d));
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic [31:0] e;
      e = model(1'b0, a, '0);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, e);
   endtask : rd

   // Sends one request of random size and compares the looked-up result.
   task automatic req(input logic [7:0] pid, input logic sp, input int gap);
      part_narrow_pkg::res_t e;
      logic [6:0] b;
      int ip, s;
      bit ok;
      b = 7'($urandom_range(127));
      ip = map_m[sp][pid];
      s = (ip < 0) ? 0 : ip;
      e = '{pid, sp, 8'(s), ip < 0, cfg_m[sp][s][0][15:0], {cfg_m[sp][s][1][15:0] | LOWM, 1'b1},
            cfg_m[sp][s][2][15:0], {cfg_m[sp][s][3][15:0] | LOWM, 1'b1}, cfg_m[sp][s][4][31],
            cfg_m[sp][s][4][15:0], (b < 7'h40) ? 7'h40 : b};
      src_u.send(pid, sp, b, gap);
      #1;
      if (ip < 0) begin
         err_m = 3;
         ok = {res_o.req_pid, res_o.space, res_o.bad_map, res_o.cost}
              === {e.req_pid, e.space, e.bad_map, e.cost};
      end else begin
         ok = res_o === e;
      end
      cmp_count++;
      if (res_valid_o !== 1'b1 || !ok) begin
         err_total++;
         $display("[ERR] %0t result %h expected %h", $time, res_o, e);
      end
   endtask : req

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         end_of_test();
      end
   end

   initial begin
      rst_i = 1'b1;
      addr_i = '0;
      wdata_i = '0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      {sel_id, sel_int, sel_sp, err_m} = '0;
      cmask = '{32'hffff, {16'h0, ~LOWM}, 32'hffff, {16'h0, ~LOWM}, 32'h8000_ffff};
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < 256; i++) map_m[s][i] = (i == 0) ? 0 : -1;
         for (int k = 0; k < 5; k++) cfg_m[s][0][k] = (k < 4) ? 32'hffff & cmask[k] : '0;
      end
      void'($urandom(32'h5646));
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(part_narrow_pkg::FEAT_OFS);
      chk(rdata_n_o, {16'(NI), 16'h0003});
      rd(part_narrow_pkg::IDENT_OFS);
      rd(part_narrow_pkg::VFEAT_OFS);
      chk(rdata_n_o, 32'h0001_0000);
      rd(8'h3c);
      req(8'h00, 1'b0, 0);
      req(8'h00, 1'b1, 0);
      wr(part_narrow_pkg::SEL_OFS, 32'h0000_0000);
      rd(part_narrow_pkg::CMAX_OFS);
      chk(rdata_n_o, {16'h0, ~LOWM});
      rd(part_narrow_pkg::MAP_OFS);
      wr(part_narrow_pkg::SEL_OFS, 32'h0001_0000);
      rd(part_narrow_pkg::CMAX_OFS);
      wr(part_narrow_pkg::SEL_OFS, 32'h0100_0005);
      wr(part_narrow_pkg::MAP_OFS, 32'h0000_0003);
      rd(part_narrow_pkg::MAP_OFS);
      wr(part_narrow_pkg::SEL_OFS, 32'h0101_0003);
      for (int k = 0; k < 5; k++) begin
         wr(8'(8'h18 + 4 * k), $urandom);
         rd(8'(8'h18 + 4 * k));
      end
      wr(part_narrow_pkg::BMAX_OFS, 32'h0000_7fff);
      rd(part_narrow_pkg::BMAX_OFS);
      req(8'h05, 1'b1, 2);
      chk(32'({res_n_valid_o, res_n_o.bad_map, res_n_o.int_pid}), 32'h0000_0205);
      fork
         wr(part_narrow_pkg::ERR_OFS, 32'h0);
         req(8'h05, 1'b0, 0);
      join
      rd(part_narrow_pkg::ERR_OFS);
      wr(part_narrow_pkg::ERR_OFS, 32'h0);
      rd(part_narrow_pkg::MAP_OFS);
      rd(part_narrow_pkg::ERR_OFS);
      wr(part_narrow_pkg::SEL_OFS, 32'h0101_0006);
      rd(part_narrow_pkg::CMAX_OFS);
      rd(part_narrow_pkg::ERR_OFS);
      wr(part_narrow_pkg::SEL_OFS, 32'h0100_0005);
      wr(part_narrow_pkg::MAP_OFS, 32'h0000_0006);
      rd(part_narrow_pkg::ERR_OFS);
      wr(part_narrow_pkg::CPOR_OFS, 32'h0000_0001);
      rd(part_narrow_pkg::ERR_OFS);
      rd(part_narrow_pkg::MAP_OFS);
      req(8'h05, 1'b1, 0);
      end_of_test();
   end
endmodule : testbench
